// File: bench/pst_sequencer_bench.sv
// Self-checking bench of the sequencer: register table, then sequencing cases.
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module pst_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] CFG = 16'h87d0, PTR = 16'h87d4, RUN = 16'h87d8;
    typedef struct {logic [15:0] a; logic w; logic [31:0] d; logic [31:0] x; logic e;} pst_row_s;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic position_reached = 1'b0, pready, pslverr, target_strobe, sequence_active, err;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic signed [31:0] target_position;
    int n_mismatch = 0, n_compared = 0, n, k;
    int unit [3] = '{1, 1000, 60000};
    pst_row_s rows [14] = '{
        '{CFG, 1'b0, 32'h0, 32'h0, 1'b0}, '{PTR, 1'b0, 32'h0, 32'h0, 1'b0},
        '{16'h87f8, 1'b0, 32'h0, 32'h0, 1'b0}, '{CFG, 1'b1, 32'hffff, 32'h0, 1'b0},
        '{CFG, 1'b0, 32'h0, 32'h1d, 1'b0}, '{16'h8834, 1'b1, 32'h8000_0001, 32'h0, 1'b0},
        '{16'h8834, 1'b0, 32'h0, 32'h8000_0001, 1'b0}, '{16'h8924, 1'b1, 32'hffff_ffff, 32'h0, 1'b0},
        '{16'h8924, 1'b0, 32'h0, 32'hffff, 1'b0}, '{PTR, 1'b1, 32'hffff_ff07, 32'h0, 1'b0},
        '{PTR, 1'b0, 32'h0, 32'h7, 1'b0}, '{16'h87e0, 1'b1, 32'h1234, 32'h0, 1'b0},
        '{16'h87e0, 1'b0, 32'h0, 32'h0, 1'b0}, '{16'h8000, 1'b0, 32'h0, 32'h0, 1'b1}};
    pst_sequencer #(.CYCLES_PER_MS(1)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .position_reached(position_reached),
        .target_position(target_position), .target_strobe(target_strobe),
        .sequence_active(sequence_active));
    task automatic apb(input logic [15:0] a, input logic w, input logic [31:0] d);
        int t;
        t = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        if (t >= 50) begin
            n_mismatch++;
            complete_run;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask
    // Counts edges up to the next strobe; a result equal to the limit means none came before the last counted edge.
    task automatic wstb(input int lim);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (target_strobe !== 1'b1 && n < lim);
    endtask
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always #20 pclk = ~pclk;
    initial begin
        repeat (90000) @(posedge pclk);
        n_mismatch++;
        complete_run;
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK("outputs", 68'h0, {prdata, pready, pslverr, target_position, target_strobe,
            sequence_active})
        foreach (rows[i]) begin
            apb(rows[i].a, rows[i].w, rows[i].d);
            `CHK("register", rows[i].x, rd)
            `CHK("error", rows[i].e, err)
        end
        wr(16'h87f8, 32'h100);
        wr(16'h88e8, 32'h3);
        wr(16'h87fc, 32'h200);
        wr(16'h88ec, 32'h1);
        wr(16'h88f0, 32'h1);
        wr(CFG, 32'h0);
        wr(PTR, 32'h0);
        wr(RUN, 32'h1);
        wstb(20);
        `CHK("first target", 32'h100, target_position)
        wstb(100);
        k = n;
        `CHK("second target", 32'h200, target_position)
        wstb(100);
        `CHK("dwell spacing", 2, k - n)
        k = n - 1;
        repeat (20) @(posedge pclk);
        `CHK("stopped on zero", 1'b0, sequence_active)
        apb(PTR, 1'b0, 32'h0);
        `CHK("pointer", 32'h3, rd)
        apb(16'h87dc, 1'b0, 32'h0);
        `CHK("done", 1'b1, rd[3])
        wr(16'h88f8, 32'h1);
        wr(16'h88fc, 32'h1);
        for (int s = 0; s < 3; s++) begin
            wr(CFG, 32'(s) << 2);
            wr(PTR, 32'h4);
            wr(RUN, 32'h1);
            wstb(20);
            wstb(70000);
            `CHK("scaled dwell", unit[s] + k, n)
            wr(RUN, 32'h0);
            @(posedge pclk);
            `CHK("aborted", 1'b0, sequence_active)
        end
        wr(16'h8924, 32'h0);
        wr(CFG, 32'h11);
        wr(PTR, 32'hf);
        wr(RUN, 32'h1);
        wstb(20);
        `CHK("last target", 32'h8000_0001, target_position)
        wstb(30);
        `CHK("held", 30, n)
        apb(16'h87dc, 1'b0, 32'h0);
        `CHK("waiting status", 32'h3, rd)
        position_reached <= 1'b1;
        wstb(30);
        position_reached <= 1'b0;
        `CHK("wrapped target", 32'h100, target_position)
        wstb(30);
        `CHK("held again", 30, n)
        apb(PTR, 1'b0, 32'h0);
        `CHK("wrapped pointer", 32'h0, rd)
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK("reset stop", 1'b0, sequence_active)
        apb(CFG, 1'b0, 32'h0);
        `CHK("reset config", 32'h0, rd)
        complete_run;
    end
endmodule
bind pst_sequencer pst_sequencer_sva #(.CYCLES_PER_MS(CYCLES_PER_MS)) chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .position_reached(position_reached), .target_position(target_position),
    .target_strobe(target_strobe), .sequence_active(sequence_active));

// File: bench/pst_sequencer_sva.sv
// Checker of bus and sequencing relations at the sequencer ports.
module pst_sequencer_sva #(
    parameter int CYCLES_PER_MS = pst_pkg::CYCLES_PER_MS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic position_reached,
    input wire logic signed [31:0] target_position,
    input wire logic target_strobe,
    input wire logic sequence_active
);
    logic mode_reg, mode_next, seen_reg, seen_next, prev_reg, prev_next;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A report in the strobe cycle is stale, so only later cycles count as arrival.
    always_comb begin
        mode_next = mode_reg;
        if (pready && pwrite && paddr == 16'h87d0)
            mode_next = pwdata[0];
        seen_next = target_strobe ? 1'b0 : (seen_reg | position_reached);
        prev_next = sequence_active & (prev_reg | target_strobe);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= 1'b0;
            seen_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            seen_reg <= seen_next;
            prev_reg <= prev_next;
        end
    end
    setup_answer_a: assert property (psel && !penable |=> pready && psel && penable)
        else $error("no answer in the cycle after setup");
    ready_cause_a: assert property (pready |-> penable && $past(psel && !penable))
        else $error("ready without a preceding setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error flag outside an answer");
    rdata_idle_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
        else $error("read data outside a read answer");
    strobe_pulse_a: assert property (target_strobe |=> !target_strobe)
        else $error("target strobe longer than one cycle");
    strobe_active_a: assert property (target_strobe |-> sequence_active)
        else $error("target issued while idle");
    target_hold_a: assert property (!target_strobe |-> $stable(target_position))
        else $error("target changed without strobe");
    reach_wait_a: assert property (mode_reg && target_strobe && prev_reg |-> seen_reg)
        else $error("entry advanced before position reached");
endmodule

// File: rtl/pst_dwell_timer.sv
// Dwell timer counting milliseconds, seconds or minutes from a one-cycle start.
module pst_dwell_timer #(
    parameter int CYCLES_PER_MS = pst_pkg::CYCLES_PER_MS
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic start,
    input wire logic abort,
    input wire logic [15:0] count,
    input wire logic [1:0] scale,
    // Result
    output logic expire
);

    logic busy_reg, busy_next;
    logic [31:0] cyc_reg, cyc_next;
    logic [16:0] ms_reg, ms_next;
    logic [16:0] ms_per_unit_reg, ms_per_unit_next;
    logic [15:0] left_reg, left_next;
    logic expire_reg, expire_next;
    logic ms_tick;
    logic unit_tick;

    // The base millisecond enable only runs while a dwell is in progress, so each
    // dwell starts on a whole-millisecond boundary of its own.
    assign ms_tick = busy_reg && (cyc_reg == 32'(CYCLES_PER_MS - 1));
    assign unit_tick = ms_tick && (ms_reg == ms_per_unit_reg - 17'h00001);
    assign expire = expire_reg;

    always_comb begin
        busy_next = busy_reg;
        cyc_next = cyc_reg;
        ms_next = ms_reg;
        ms_per_unit_next = ms_per_unit_reg;
        left_next = left_reg;
        expire_next = 1'b0;
        if (abort) begin
            busy_next = 1'b0;
        end else if (start) begin
            cyc_next = 32'h0000_0000;
            ms_next = 17'h00000;
            left_next = count;
            case (scale)
                pst_pkg::SCALE_MS: ms_per_unit_next = 17'h00001;
                pst_pkg::SCALE_S: ms_per_unit_next = pst_pkg::MS_PER_S;
                pst_pkg::SCALE_MIN: ms_per_unit_next = pst_pkg::MS_PER_MIN;
                default: ms_per_unit_next = pst_pkg::MS_PER_MIN;
            endcase
            // A zero count expires at once; the sequencer decides what zero means.
            if (count == 16'h0000) begin
                expire_next = 1'b1;
            end else begin
                busy_next = 1'b1;
            end
        end else if (busy_reg) begin
            cyc_next = ms_tick ? 32'h0000_0000 : cyc_reg + 32'h0000_0001;
            if (ms_tick) begin
                ms_next = unit_tick ? 17'h00000 : ms_reg + 17'h00001;
            end
            if (unit_tick) begin
                left_next = left_reg - 16'h0001;
                if (left_reg == 16'h0001) begin
                    busy_next = 1'b0;
                    expire_next = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_reg <= 1'b0;
            cyc_reg <= 32'h0000_0000;
            ms_reg <= 17'h00000;
            ms_per_unit_reg <= 17'h00001;
            left_reg <= 16'h0000;
            expire_reg <= 1'b0;
        end else begin
            busy_reg <= busy_next;
            cyc_reg <= cyc_next;
            ms_reg <= ms_next;
            ms_per_unit_reg <= ms_per_unit_next;
            left_reg <= left_next;
            expire_reg <= expire_next;
        end
    end

endmodule

// File: rtl/pst_pkg.sv
// Package of constants for the position sequence table stepper.
package pst_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [13:0] CONFIG_IDX = 14'h21f4;
    localparam logic [13:0] POINTER_IDX = 14'h21f5;
    localparam logic [13:0] RUN_IDX = 14'h21f6;
    localparam logic [13:0] STATUS_IDX = 14'h21f7;
    localparam logic [13:0] TARGET_OUT_IDX = 14'h21f8;
    localparam logic [13:0] POS_TABLE_IDX = 14'h21fe;
    localparam logic [13:0] DWELL_TABLE_IDX = 14'h223a;

    // Table geometry.
    localparam int TABLE_DEPTH = 16;
    localparam int INDEX_W = 4;
    localparam logic [3:0] LAST_ENTRY = 4'hf;

    // Field positions of sequence_config.
    localparam int CFG_DELAY_MODE_BIT = 0;
    localparam int CFG_SCALE_LO_BIT = 2;
    localparam int CFG_SCALE_HI_BIT = 3;
    localparam int CFG_REPEAT_BIT = 4;
    localparam logic [15:0] CFG_WRITE_MASK = 16'h001d;

    // Field positions of the run and status registers.
    localparam int RUN_ENABLE_BIT = 0;
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_WAIT_POS_BIT = 1;
    localparam int STAT_TIMING_BIT = 2;
    localparam int STAT_DONE_BIT = 3;

    // Reset values.
    localparam logic [15:0] CONFIG_RESET = 16'h0000;
    localparam logic [3:0] POINTER_RESET = 4'h0;
    localparam logic [31:0] POS_RESET = 32'h0000_0000;
    localparam logic [15:0] DWELL_RESET = 16'h0000;

    // Time scale codes.
    localparam logic [1:0] SCALE_MS = 2'b00;
    localparam logic [1:0] SCALE_S = 2'b01;
    localparam logic [1:0] SCALE_MIN = 2'b10;

    // Timing: one millisecond base tick derived from the 40 ns clock.
    localparam int CLK_PERIOD_NS = 40;
    localparam int MS_TICK_NS = 1000000;
    localparam int CYCLES_PER_MS = MS_TICK_NS / CLK_PERIOD_NS;
    localparam logic [16:0] MS_PER_S = 17'h003e8;
    localparam logic [16:0] MS_PER_MIN = 17'h0ea60;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_LOAD = 4'b0010,
        ST_WAIT_POS = 4'b0100,
        ST_TIMING = 4'b1000
    } pst_state_e;

endpackage

// File: rtl/pst_sequencer.sv
// Sequence table stepper with APB register access and position target output.
//
// Function
// - Delay mode 0 starts dwell immediately.
// - Mode 0 advances on expiry, reached or not.
// - Delay mode 1 waits for position reached.
// - Two-bit field picks ms, s or min.
// - Repeat clear stops on zero dwell entry.
// - Repeat set does not stop on zero dwell entries.
// - Pointer increments per finished table entry, except the last one with repeat clear.
// - Targets are signed 1/4096 revolution counts.
// - Dwell values count the selected time unit.
module pst_sequencer #(
    parameter int CYCLES_PER_MS = pst_pkg::CYCLES_PER_MS
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Regulator side
    input wire logic position_reached,
    output logic signed [31:0] target_position,
    output logic target_strobe,
    output logic sequence_active
);

    // Returns 1 when the word index lies within a 16-entry table at base.
    function automatic logic in_table(input logic [13:0] idx, input logic [13:0] base);
        in_table = (idx >= base) && (idx < base + 14'(pst_pkg::TABLE_DEPTH));
    endfunction

    // Register storage.
    logic [15:0] config_reg, config_next;
    logic [3:0] pointer_reg, pointer_next;
    logic run_reg, run_next;
    logic done_reg, done_next;
    logic signed [31:0] pos_mem [pst_pkg::TABLE_DEPTH];
    logic [15:0] dwell_mem [pst_pkg::TABLE_DEPTH];

    // Bus answer registers.
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;

    // Sequencer registers.
    pst_pkg::pst_state_e state_reg, state_next;
    logic signed [31:0] target_reg, target_next;
    logic strobe_reg, strobe_next;
    logic timer_start;
    logic timer_abort;
    logic timer_expire;

    logic [13:0] widx;
    logic wr_en;
    logic setup;
    logic mapped;
    logic [3:0] pos_sel;
    logic [3:0] dwell_sel;
    logic delay_mode;
    logic repeat_on;
    logic [1:0] scale;
    logic [15:0] cur_dwell;

    assign widx = paddr[15:2];
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready_reg && pwrite;
    assign pos_sel = 4'(widx - pst_pkg::POS_TABLE_IDX);
    assign dwell_sel = 4'(widx - pst_pkg::DWELL_TABLE_IDX);
    assign delay_mode = config_reg[pst_pkg::CFG_DELAY_MODE_BIT];
    assign repeat_on = config_reg[pst_pkg::CFG_REPEAT_BIT];
    assign scale = config_reg[pst_pkg::CFG_SCALE_HI_BIT:pst_pkg::CFG_SCALE_LO_BIT];
    assign cur_dwell = dwell_mem[pointer_reg];

    assign mapped = (widx == pst_pkg::CONFIG_IDX) || (widx == pst_pkg::POINTER_IDX) ||
                    (widx == pst_pkg::RUN_IDX) || (widx == pst_pkg::STATUS_IDX) ||
                    (widx == pst_pkg::TARGET_OUT_IDX) ||
                    in_table(widx, pst_pkg::POS_TABLE_IDX) ||
                    in_table(widx, pst_pkg::DWELL_TABLE_IDX);

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign target_position = target_reg;
    assign target_strobe = strobe_reg;
    assign sequence_active = run_reg;

    // Bus answer: data is prepared in the setup cycle so the access ends in one cycle.
    always_comb begin
        prdata_next = 32'h0000_0000;
        pready_next = setup;
        pslverr_next = setup && !mapped;
        if (setup && !pwrite) begin
            if (widx == pst_pkg::CONFIG_IDX) begin
                prdata_next = {16'h0000, config_reg};
            end else if (widx == pst_pkg::POINTER_IDX) begin
                prdata_next = {28'h0000000, pointer_reg};
            end else if (widx == pst_pkg::RUN_IDX) begin
                prdata_next = {31'h00000000, run_reg};
            end else if (widx == pst_pkg::STATUS_IDX) begin
                prdata_next[pst_pkg::STAT_ACTIVE_BIT] = run_reg;
                prdata_next[pst_pkg::STAT_WAIT_POS_BIT] = (state_reg == pst_pkg::ST_WAIT_POS);
                prdata_next[pst_pkg::STAT_TIMING_BIT] = (state_reg == pst_pkg::ST_TIMING);
                prdata_next[pst_pkg::STAT_DONE_BIT] = done_reg;
            end else if (widx == pst_pkg::TARGET_OUT_IDX) begin
                prdata_next = target_reg;
            end else if (in_table(widx, pst_pkg::POS_TABLE_IDX)) begin
                prdata_next = pos_mem[pos_sel];
            end else if (in_table(widx, pst_pkg::DWELL_TABLE_IDX)) begin
                prdata_next = {16'h0000, dwell_mem[dwell_sel]};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // Tables: software writes only; the sequencer reads them.
    // Each slot decodes its own write, so one bus write touches at most one slot.
    for (genvar g = 0; g < pst_pkg::TABLE_DEPTH; g++) begin : g_slot
        logic signed [31:0] pos_next;
        logic [15:0] dwell_next;

        always_comb begin
            pos_next = pos_mem[g];
            dwell_next = dwell_mem[g];
            if (wr_en && in_table(widx, pst_pkg::POS_TABLE_IDX) && pos_sel == 4'(g)) begin
                pos_next = pwdata;
            end
            if (wr_en && in_table(widx, pst_pkg::DWELL_TABLE_IDX) && dwell_sel == 4'(g)) begin
                dwell_next = pwdata[15:0];
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pos_mem[g] <= pst_pkg::POS_RESET;
                dwell_mem[g] <= pst_pkg::DWELL_RESET;
            end else begin
                pos_mem[g] <= pos_next;
                dwell_mem[g] <= dwell_next;
            end
        end
    end

    // Sequencer and control registers.
    always_comb begin
        config_next = config_reg;
        pointer_next = pointer_reg;
        run_next = run_reg;
        done_next = done_reg;
        state_next = state_reg;
        target_next = target_reg;
        strobe_next = 1'b0;
        timer_start = 1'b0;
        timer_abort = 1'b0;
        case (state_reg)
            pst_pkg::ST_IDLE: begin
                if (run_reg) begin
                    state_next = pst_pkg::ST_LOAD;
                end
            end
            pst_pkg::ST_LOAD: begin
                if (cur_dwell == 16'h0000 && !repeat_on) begin
                    run_next = 1'b0;
                    done_next = 1'b1;
                    state_next = pst_pkg::ST_IDLE;
                end else begin
                    // The target moves here even when a stop written in the load cycle suppresses its strobe,
                    // so a refused entry changes target_position without a strobe to the regulator.
                    target_next = pos_mem[pointer_reg];
                    strobe_next = 1'b1;
                    if (delay_mode) begin
                        state_next = pst_pkg::ST_WAIT_POS;
                    end else begin
                        timer_start = 1'b1;
                        state_next = pst_pkg::ST_TIMING;
                    end
                end
            end
            pst_pkg::ST_WAIT_POS: begin
                if (position_reached && !strobe_reg) begin
                    timer_start = 1'b1;
                    state_next = pst_pkg::ST_TIMING;
                end
            end
            pst_pkg::ST_TIMING: begin
                // Expiry alone moves on; position_reached is not looked at here.
                if (timer_expire) begin
                    if (pointer_reg == pst_pkg::LAST_ENTRY && !repeat_on) begin
                        run_next = 1'b0;
                        done_next = 1'b1;
                        state_next = pst_pkg::ST_IDLE;
                    end else begin
                        // A zero dwell with repeat set just passes through here.
                        pointer_next = pointer_reg + 4'h1;
                        state_next = pst_pkg::ST_LOAD;
                    end
                end
            end
            default: begin
                state_next = pst_pkg::ST_IDLE;
            end
        endcase
        if (wr_en) begin
            if (widx == pst_pkg::CONFIG_IDX) begin
                config_next = pwdata[15:0] & pst_pkg::CFG_WRITE_MASK;
            end
            // A software write to the pointer outranks the sequencer's own step.
            if (widx == pst_pkg::POINTER_IDX) begin
                pointer_next = pwdata[3:0];
            end
            if (widx == pst_pkg::RUN_IDX) begin
                run_next = pwdata[pst_pkg::RUN_ENABLE_BIT];
                if (pwdata[pst_pkg::RUN_ENABLE_BIT]) begin
                    done_next = 1'b0;
                end else begin
                    // A stop in the load cycle must not issue a target while idle.
                    strobe_next = 1'b0;
                    timer_abort = 1'b1;
                    state_next = pst_pkg::ST_IDLE;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_reg <= pst_pkg::CONFIG_RESET;
            pointer_reg <= pst_pkg::POINTER_RESET;
            run_reg <= 1'b0;
            done_reg <= 1'b0;
            state_reg <= pst_pkg::ST_IDLE;
            target_reg <= pst_pkg::POS_RESET;
            strobe_reg <= 1'b0;
        end else begin
            config_reg <= config_next;
            pointer_reg <= pointer_next;
            run_reg <= run_next;
            done_reg <= done_next;
            state_reg <= state_next;
            target_reg <= target_next;
            strobe_reg <= strobe_next;
        end
    end

    pst_dwell_timer #(
        .CYCLES_PER_MS(CYCLES_PER_MS)
    ) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .start(timer_start),
        .abort(timer_abort),
        .count(cur_dwell),
        .scale(scale),
        .expire(timer_expire)
    );

endmodule
